// ===== logic/odlc_delay.sv
`timescale 1ns/10ps
module odlc_delay #(
   parameter int DLY_W = 10
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // Step tick and source level.
   input wire logic i_tick,
   input wire logic i_src,
   // Delay settings in steps.
   input wire logic [DLY_W-1:0] i_on_dly,
   input wire logic [DLY_W-1:0] i_off_dly,
   // Delayed level.
   output logic o_out
);
   initial begin
      if (DLY_W < 1) $error("odlc_delay: DLY_W must be at least 1.");
   end

   logic out_reg, out_next;
   logic [DLY_W-1:0] cnt_reg, cnt_next;

   // The delay that applies is the one for the edge that would come next.
   wire logic [DLY_W-1:0] dly_sel = out_reg ? i_off_dly : i_on_dly;
   wire logic mismatch = (i_src != out_reg);
   // The count starts on a partial step, so one extra step is waited to never cut a delay short.
   wire logic hit = mismatch && ((dly_sel == '0) || (i_tick && (cnt_reg >= dly_sel)));

   // Any return of the source to the output level throws the count away.
   always_comb begin
      out_next = hit ? i_src : out_reg;
      if (!mismatch || hit) begin
         cnt_next = '0;
      end else if (i_tick) begin
         cnt_next = cnt_reg + 1'b1;
      end else begin
         cnt_next = cnt_reg;
      end
   end

   // State registers.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         out_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         out_reg <= out_next;
         cnt_reg <= cnt_next;
      end
   end

   assign o_out = out_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   a_rise_needs_src: assert property ($rose(out_reg) |-> $past(i_src) && $past(cnt_reg >= i_on_dly))
      else $error("Output rose without source or full delay.");
   a_zero_delay_follow: assert property (mismatch && dly_sel == '0 |=> out_reg == $past(i_src))
      else $error("Zero delay did not follow source.");
   a_hold_between_ticks: assert property (dly_sel != '0 && !i_tick |=> $stable(out_reg))
      else $error("Output changed without a step tick.");
   a_match_stable: assert property (!mismatch |=> $stable(out_reg))
      else $error("Output changed while equal to source.");
endmodule : odlc_delay

// ===== logic/odlc_logic.sv
`timescale 1ns/10ps
module odlc_logic #(
   parameter int NFUNC = 64,
   parameter int SEL_W = 6
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // Selectable output functions.
   input wire logic [NFUNC-1:0] i_func,
   // Settings.
   input wire logic [SEL_W-1:0] i_sel_a,
   input wire logic [SEL_W-1:0] i_sel_b,
   input wire logic [1:0] i_op,
   // Combined level.
   output logic o_out
);
   initial begin
      if (NFUNC < 1 || NFUNC > (1 << SEL_W)) $error("odlc_logic: NFUNC does not fit SEL_W.");
   end

   // A code beyond the function list reads as an inactive operand.
   function automatic logic pick(input logic [NFUNC-1:0] f, input logic [SEL_W-1:0] s);
      pick = (int'(s) < NFUNC) ? f[s] : 1'b0;
   endfunction : pick

   logic out_reg;
   wire logic opa = pick(i_func, i_sel_a);
   wire logic opb = pick(i_func, i_sel_b);
   wire logic res_and = opa & opb;
   wire logic res_or = opa | opb;
   wire logic res_xor = opa ^ opb;
   // Code 03 is refused at the register, so default only guards.
   wire logic out_next = (i_op == odlc_pkg::ODLC_OP_OR) ? res_or :
                         (i_op == odlc_pkg::ODLC_OP_XOR) ? res_xor : res_and;

   // Output register.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         out_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
      end
   end

   assign o_out = out_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   a_and_result: assert property (i_op == odlc_pkg::ODLC_OP_AND |=> out_reg == $past(opa & opb))
      else $error("AND result wrong.");
   a_xor_result: assert property (i_op == odlc_pkg::ODLC_OP_XOR |=> out_reg == $past(opa ^ opb))
      else $error("XOR result wrong.");
endmodule : odlc_logic

// ===== logic/odlc_pkg.sv
package odlc_pkg;
   // Delay settings are counted in steps of one tenth of a second.
   localparam int ODLC_STEP_MS = 100;
   localparam int ODLC_CLK_KHZ = 20000;
   localparam int ODLC_STEP_CYCLES = ODLC_STEP_MS * ODLC_CLK_KHZ;
   // Largest delay in steps, that is 100.0 seconds, and the reset value.
   localparam logic [15:0] ODLC_DLY_MAX = 16'h03E8;
   localparam logic [15:0] ODLC_DLY_RST = 16'h0000;
   localparam int ODLC_DLY_W = 10;
   // Operand selection after reset.
   localparam logic [15:0] ODLC_SEL_RST = 16'h0000;
   // Operator encoding.
   typedef enum logic [1:0] {
      ODLC_OP_AND = 2'h0,
      ODLC_OP_OR = 2'h1,
      ODLC_OP_XOR = 2'h2
   } odlc_op_type;
   localparam logic [1:0] ODLC_OP_RST = 2'h0;
   // Terminal and channel counts.
   localparam int ODLC_NTERM = 5;
   localparam int ODLC_NCHAN = 6;
   localparam int ODLC_NLOG = 6;
   // Register word indices.
   localparam logic [7:0] ODLC_ADR_DLY = 8'h00;
   localparam logic [7:0] ODLC_ADR_LOG = 8'h10;
   localparam logic [7:0] ODLC_ADR_STATUS = 8'h30;
   localparam logic [7:0] ODLC_ADR_SOURCE = 8'h31;
   localparam int ODLC_NWORDS = 64;
   // Status word field positions.
   localparam int ODLC_ST_TERM = 0;
   localparam int ODLC_ST_RELAY = 5;
   localparam int ODLC_ST_LOG = 8;
endpackage : odlc_pkg

// ===== logic/odlc_top.sv
// Function
// - Each of the five output terminals has an on delay of 0.0 to 100.0 s in 0.1 s steps, reset to 0.0.
// - Each of the five output terminals has its own off delay of 0.0 to 100.0 s in 0.1 s steps, reset to 0.0.
// - The alarm relay output has its own on and off delays, each 0.0 to 100.0 s, reset to 0.0.
// - Each of six derived logic signals picks two operands from the output function list, reset to code 00.
// - Each derived logic signal combines its operands by AND for 00, OR for 01 and XOR for 02.
// - After reset every operator selection reads 00, that is AND.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module odlc_top #(
   parameter int NFUNC = 64,
   parameter int SEL_W = 6,
   parameter int TICK_CYCLES = odlc_pkg::ODLC_STEP_CYCLES
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // Register port.
   input wire logic [7:0] i_adr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // Output function levels and terminal sources.
   input wire logic [NFUNC-1:0] i_func,
   input wire logic [4:0] i_term_src,
   input wire logic i_relay_src,
   // Conditioned outputs.
   output logic [4:0] o_term,
   output logic o_alarm_relay_output,
   output logic [5:0] o_derived_logic_signal
);
   initial begin
      if (TICK_CYCLES < 1) $error("odlc_top: TICK_CYCLES must be at least 1.");
      if (SEL_W < 1 || SEL_W > 16) $error("odlc_top: SEL_W must be 1 to 16.");
   end

   localparam int NCH = odlc_pkg::ODLC_NCHAN;
   localparam int NLG = odlc_pkg::ODLC_NLOG;
   localparam int DW = odlc_pkg::ODLC_DLY_W;

   ////////////////////////////////////////////////////////////////////////////
   // Settings storage.

   logic [DW-1:0] dly_reg [0:2*NCH-1];
   logic [SEL_W-1:0] sela_reg [0:NLG-1];
   logic [SEL_W-1:0] selb_reg [0:NLG-1];
   logic [1:0] op_reg [0:NLG-1];
   logic [15:0] rdata_reg;
   logic [31:0] pre_reg;
   logic tick_reg;
   logic [4:0] term_w;
   logic relay_w;
   logic [5:0] log_w;

   // Writes above the top of the range saturate, so a bad value cannot wrap into a short delay.
   function automatic logic [DW-1:0] clamp(input logic [15:0] d);
      clamp = (d > odlc_pkg::ODLC_DLY_MAX) ? odlc_pkg::ODLC_DLY_MAX[DW-1:0] : d[DW-1:0];
   endfunction : clamp

   // A write lands on one word chosen by its index.
   function automatic logic hit_wr(input logic wr, input logic [7:0] a, input logic [7:0] idx);
      hit_wr = wr && (a == idx);
   endfunction : hit_wr

   wire logic op_ok = (i_wdata[15:2] == 14'h0000) && (i_wdata[1:0] != 2'h3);

   genvar g;
   generate
      // Delay words: terminal k on at 2k, off at 2k+1; relay at 10 and 11.
      for (g = 0; g < 2 * NCH; g++) begin : g_dly
         wire logic we = hit_wr(i_wr, i_adr, odlc_pkg::ODLC_ADR_DLY + 8'(g));
         always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               dly_reg[g] <= odlc_pkg::ODLC_DLY_RST[DW-1:0];
            end else if (we) begin
               dly_reg[g] <= clamp(i_wdata);
            end
         end
      end
      // Logic words: signal j operand A at 16+3j, operand B next, operator after.
      for (g = 0; g < NLG; g++) begin : g_log
         wire logic we_a = hit_wr(i_wr, i_adr, odlc_pkg::ODLC_ADR_LOG + 8'(3 * g));
         wire logic we_b = hit_wr(i_wr, i_adr, odlc_pkg::ODLC_ADR_LOG + 8'(3 * g + 1));
         wire logic we_o = hit_wr(i_wr, i_adr, odlc_pkg::ODLC_ADR_LOG + 8'(3 * g + 2));
         always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               sela_reg[g] <= odlc_pkg::ODLC_SEL_RST[SEL_W-1:0];
               selb_reg[g] <= odlc_pkg::ODLC_SEL_RST[SEL_W-1:0];
            end else begin
               if (we_a) sela_reg[g] <= i_wdata[SEL_W-1:0];
               if (we_b) selb_reg[g] <= i_wdata[SEL_W-1:0];
            end
         end
         // An unknown operator code is refused and the old operator kept.
         always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               op_reg[g] <= odlc_pkg::ODLC_OP_RST;
            end else if (we_o && op_ok) begin
               op_reg[g] <= i_wdata[1:0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Step prescaler.

   // One shared divider keeps area low; the price is up to one step of extra delay per change.
   wire logic pre_end = (pre_reg >= 32'(TICK_CYCLES - 1));
   wire logic [31:0] pre_next = pre_end ? 32'h00000000 : pre_reg + 32'h00000001;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pre_reg <= 32'h00000000;
         tick_reg <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         tick_reg <= pre_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Delay channels and logic combiners.

   wire logic [5:0] ch_src = {i_relay_src, i_term_src};
   wire logic [5:0] ch_out;

   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         odlc_delay #(.DLY_W(DW)) u_dly (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_tick(tick_reg),
            .i_src(ch_src[g]),
            .i_on_dly(dly_reg[2*g]),
            .i_off_dly(dly_reg[2*g+1]),
            .o_out(ch_out[g])
         );
      end
      for (g = 0; g < NLG; g++) begin : g_lg
         odlc_logic #(.NFUNC(NFUNC), .SEL_W(SEL_W)) u_log (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_func(i_func),
            .i_sel_a(sela_reg[g]),
            .i_sel_b(selb_reg[g]),
            .i_op(op_reg[g]),
            .o_out(log_w[g])
         );
      end
   endgenerate

   assign term_w = ch_out[4:0];
   assign relay_w = ch_out[5];

   ////////////////////////////////////////////////////////////////////////////
   // Read path.

   logic [15:0] rd_word [0:odlc_pkg::ODLC_NWORDS-1];
   wire logic [15:0] status_w = {2'h0, log_w, 2'h0, relay_w, term_w};
   wire logic [15:0] source_w = {10'h000, i_relay_src, i_term_src};

   // Every word of the window is defined; unused indices read as zero.
   generate
      for (g = 0; g < odlc_pkg::ODLC_NWORDS; g++) begin : g_rd
         if (g < 2 * NCH) begin : g_d
            assign rd_word[g] = 16'(dly_reg[g]);
         end else if (g >= 16 && g < 16 + 3 * NLG && (g - 16) % 3 == 0) begin : g_a
            assign rd_word[g] = 16'(sela_reg[(g-16)/3]);
         end else if (g >= 16 && g < 16 + 3 * NLG && (g - 16) % 3 == 1) begin : g_b
            assign rd_word[g] = 16'(selb_reg[(g-16)/3]);
         end else if (g >= 16 && g < 16 + 3 * NLG) begin : g_o
            assign rd_word[g] = {14'h0000, op_reg[(g-16)/3]};
         end else if (g == 48) begin : g_s
            assign rd_word[g] = status_w;
         end else if (g == 49) begin : g_r
            assign rd_word[g] = source_w;
         end else begin : g_z
            assign rd_word[g] = 16'h0000;
         end
      end
   endgenerate

   wire logic [15:0] rd_mux = (i_adr < 8'(odlc_pkg::ODLC_NWORDS)) ? rd_word[i_adr[5:0]] : 16'h0000;

   // Read data stand for the one cycle after the strobe and are zero otherwise.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= i_rd ? rd_mux : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign o_rdata = rdata_reg;
   assign o_term = term_w;
   assign o_alarm_relay_output = relay_w;
   assign o_derived_logic_signal = log_w;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_dly_write_big;
      i_wr && i_adr < 8'h0C && i_wdata > odlc_pkg::ODLC_DLY_MAX;
   endsequence

   sequence s_op_write_bad;
      i_wr && i_adr == 8'h12 && !op_ok;
   endsequence

   a_dly_clamp_max: assert property (s_dly_write_big |=> rd_word[$past(i_adr[5:0])] == 16'h03E8)
      else $error("Oversized delay write not clamped.");
   a_bad_op_kept: assert property (s_op_write_bad |=> op_reg[0] == $past(op_reg[0]))
      else $error("Invalid operator code was stored.");
   a_read_status: assert property (i_rd && i_adr == odlc_pkg::ODLC_ADR_STATUS |=> o_rdata == $past(status_w))
      else $error("Status read returned wrong data.");
   a_op_reset_and: assert property ($rose(i_resetn) |-> op_reg[0] == 2'h0 && op_reg[5] == 2'h0)
      else $error("Operator not AND after reset.");
   a_tick_single: assert property (tick_reg && TICK_CYCLES > 1 |=> !tick_reg)
      else $error("Step tick longer than one cycle.");
endmodule : odlc_top

// ===== sim/odlc_load.sv
`timescale 1ns/10ps
////////////////////
// Far-side load that counts how often the terminals and relay switch on.
module odlc_load (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // Conditioned lines as the load sees them.
   input wire logic [5:0] i_lines,
   // Off-to-on switchings, a measure of contact wear.
   output logic [7:0] o_rises
);
   logic [5:0] last_reg;
   // Each rising line is one closure; a filtered glitch must not add one.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         last_reg <= 6'h00;
         o_rises <= 8'h00;
      end else begin
         last_reg <= i_lines;
         o_rises <= o_rises + 8'($countones(i_lines & ~last_reg));
      end
   end
endmodule : odlc_load

// ===== sim/test_output_delay_logic_combiner.sv
`timescale 1ns/10ps
////////////////////
module test_output_delay_logic_combiner;
   localparam int TK = 4;
   logic i_clk, i_resetn, i_wr, i_rd;
   logic [7:0] i_adr, rises, r0;
   logic [15:0] i_wdata, o_rdata, d;
   logic [63:0] func;
   logic [5:0] src, o_der, outs;
   logic [4:0] o_term;
   logic o_relay;
   int fail_count, tests_run;
   int a, b, on, off, base;

   // A short tick keeps the delay scenarios within a few hundred cycles.
   odlc_top #(.TICK_CYCLES(TK)) i_odlc_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_adr(i_adr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_func(func),
      .i_term_src(src[4:0]), .i_relay_src(src[5]), .o_term(o_term),
      .o_alarm_relay_output(o_relay), .o_derived_logic_signal(o_der));
   odlc_load i_odlc_load (.i_clk(i_clk), .i_resetn(i_resetn), .i_lines(outs), .o_rises(rises));
   assign outs = {o_relay, o_term};

   // Free-running 20 MHz clock.
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   ////////////////////
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // Bus cycles: one-cycle strobes, read data sampled in the cycle after.
   task automatic wr(input logic [7:0] ad, input logic [15:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_adr <= ad;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ad, output logic [15:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_adr <= ad;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
   endtask : rd

   function automatic logic exp_log(input logic x, input logic y, input logic [1:0] op);
      case (op)
         2'h0: return x & y;
         2'h1: return x | y;
         default: return x ^ y;
      endcase
   endfunction : exp_log

   // Moves one source and counts cycles until its output follows.
   task automatic meas(input int ch, input logic lv, input int n);
      int c, lo, hi;
      c = 0;
      lo = (n == 0) ? 1 : n * TK;
      hi = (n == 0) ? 1 : (n + 1) * TK + 2;
      @(posedge i_clk);
      src[ch] <= lv;
      #1;
      while (outs[ch] !== lv && c < 5000) begin
         @(posedge i_clk);
         #1;
         c++;
      end
      if (c == 5000) begin
         fail_count++;
         tally_and_finish();
      end
      check("delay cycles in range", 32'(c >= lo && c <= hi), 32'h1);
   endtask : meas

   ////////////////////
   // Main sequence; the seed is set once so every run repeats.
   initial begin
      i_resetn = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_adr = 8'h00;
      i_wdata = 16'h0000;
      func = 64'h0;
      src = 6'h00;
      fail_count = 0;
      tests_run = 0;
      void'($urandom(32'hE5AAF5B1));
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      for (int k = 0; k < 34; k++) begin
         if (k < 12 || k >= 16) begin
            rd(8'(k), d);
            check("setting after reset", 32'(d), 32'h0);
         end
      end
      rd(8'h3F, d);
      check("unmapped read", 32'(d), 32'h0);
      $display("test reset values done");
      // Largest delay is kept, anything above it saturates.
      wr(8'h00, 16'h03E8);
      rd(8'h00, d);
      check("on delay max", 32'(d), 32'h3E8);
      wr(8'h00, 16'h03E9);
      rd(8'h00, d);
      check("on delay clamp", 32'(d), 32'h3E8);
      wr(8'h0B, 16'hFFFF);
      rd(8'h0B, d);
      check("relay off clamp", 32'(d), 32'h3E8);
      wr(8'h00, 16'h0000);
      wr(8'h0B, 16'h0000);
      $display("test delay limits done");
      // Every operator on every derived signal with random operands.
      for (int j = 0; j < 6; j++) begin
         for (int op = 0; op < 3; op++) begin
            func <= {$urandom, $urandom};
            a = $urandom % 64;
            b = $urandom % 64;
            wr(8'(16 + 3 * j), 16'(a));
            wr(8'(17 + 3 * j), 16'(b));
            wr(8'(18 + 3 * j), 16'(op));
            @(posedge i_clk);
            @(posedge i_clk);
            #1;
            check("derived level", 32'(o_der[j]), 32'(exp_log(func[a], func[b], 2'(op))));
         end
      end
      // An undefined operator code leaves the setting alone.
      wr(8'h12, 16'h0003);
      rd(8'h12, d);
      check("operator refused", 32'(d), 32'h2);
      $display("test derived signals done");
      // Random on and off delays on each terminal and the relay.
      for (int ch = 0; ch < 6; ch++) begin
         on = $urandom % 4;
         off = $urandom % 4;
         base = (ch < 5) ? 2 * ch : 10;
         wr(8'(base), 16'(on));
         wr(8'(base + 1), 16'(off));
         meas(ch, 1'b1, on);
         meas(ch, 1'b0, off);
      end
      $display("test delays done");
      // A pulse shorter than the on delay must never reach the load.
      r0 = rises;
      wr(8'h00, 16'h0003);
      @(posedge i_clk);
      src[0] <= 1'b1;
      repeat (TK) @(posedge i_clk);
      src[0] <= 1'b0;
      repeat (5 * TK) @(posedge i_clk);
      #1;
      check("glitch filtered", 32'(o_term[0]), 32'h0);
      check("load closures", 32'(rises), 32'(r0));
      meas(0, 1'b1, 3);
      $display("test glitch done");
      // Read-only words mirror the sources and the conditioned outputs.
      rd(8'h31, d);
      check("source word", 32'(d), 32'h0001);
      @(posedge i_clk);
      #1;
      check("read data back to zero", 32'(o_rdata), 32'h0);
      // Signal 0 set to OR, the rest stay on XOR, so all-ones functions give bit 8; terminal 0, still on, gives bit 0.
      wr(8'h12, 16'h0001);
      func <= 64'hFFFFFFFFFFFFFFFF;
      @(posedge i_clk);
      @(posedge i_clk);
      rd(8'h30, d);
      check("status word", 32'(d), 32'h0101);
      $display("test status done");
      tally_and_finish();
   end
endmodule : test_output_delay_logic_combiner
